// *** hw/pbc_pkg.sv ***
// Package for the port B/C pin-function multiplexer: register map, field layout and misc-register bit positions.
// Assumes an APB slave with 32-bit data and word-aligned registers.
`default_nettype none
package pbc_pkg;
    localparam int          NPINS        = 8;
    localparam logic [7:0]  OFS_PB_MODE  = 8'h00;
    localparam logic [7:0]  OFS_PB_DIR   = 8'h04;
    localparam logic [7:0]  OFS_PB_OUT   = 8'h08;
    localparam logic [7:0]  OFS_PB_IN    = 8'h0c;
    localparam logic [7:0]  OFS_PB_SEL   = 8'h10;
    localparam logic [7:0]  OFS_PC_MODE  = 8'h14;
    localparam logic [7:0]  OFS_PC_DIR   = 8'h18;
    localparam logic [7:0]  OFS_PC_OUT   = 8'h1c;
    localparam logic [7:0]  OFS_PC_IN    = 8'h20;
    localparam logic [7:0]  OFS_PC_SEL   = 8'h24;
    localparam logic [7:0]  OFS_EDGE_POL = 8'h28;
    localparam logic [7:0]  OFS_INT_STAT = 8'h2c;
    localparam logic [7:0]  OFS_INT_MASK = 8'h30;
    localparam logic [7:0]  OFS_MISC     = 8'h34;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam int          MISC_RSTREQ  = 0;
    localparam int          MISC_DRAM_ADDR_MUX_SELECT    = 1;
    localparam int          MISC_DRAM_ADDR_MUX_SELECT_ALT   = 2;
    // Interrupt status layout: bits 3:0 edge inputs.
    localparam int          NEDGE        = 4;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] dir;
        logic [7:0] dout;
        logic [7:0] sel;
    } pbc_port_cfg_t;

    typedef struct packed {
        logic [7:0] din;
        logic [7:0] dout;
        logic [7:0] oe;
    } pbc_pins_t;
endpackage
`default_nettype wire

// *** hw/pbc_sync.sv ***
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes the output is the only reader of the second stage.
`default_nettype none
module pbc_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// *** hw/pbc_edge.sv ***
// Edge-interrupt pending flags for synchronised inputs, rising or falling per input.
// Assumes inputs are already synchronised to clk.
`default_nettype none
module pbc_edge #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Inputs and control
    input  wire logic [N-1:0] level,
    input  wire logic [N-1:0] enable,
    input  wire logic [N-1:0] rise_sel,
    input  wire logic [N-1:0] clear,
    // Pending flags
    output logic      [N-1:0] pend_q
);
    logic [N-1:0] prev_q;
    wire  [N-1:0] rise_hit = level & ~prev_q;
    wire  [N-1:0] fall_hit = ~level & prev_q;
    wire  [N-1:0] hit      = enable & ((rise_sel & rise_hit) | (~rise_sel & fall_hit));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= '0;
            pend_q <= '0;
        end else begin
            prev_q <= level;
            pend_q <= (pend_q & ~clear) | hit;
        end
    end
endmodule
`default_nettype wire

// *** hw/pbc_mux.sv ***
// Pin-function multiplexer for ports B and C with APB registers and edge interrupts.
// Assumes pads resolve oe/dout externally and pin inputs are asynchronous.
`default_nettype none
// Overview of operation
// - Every port B and C pin is chosen as general input, general output or one of its special functions.
// - Direction and function choice per pin live in software-written configuration registers.
// - Port B pin 3 in special mode feeds serial channel B receive data.
// - Port B pin 2 is either serial B data-set-ready input or DMA channel 4 acknowledge output.
// - Port B pin 1 can output the receive start-of-frame marker for external address filters.
// - Port B pin 1 can instead be serial B clear-to-send input.
// - Port B pin 0 is serial B carrier detect input or the two-way DMA channel 4 done signal.
// - Port C pin 7 is serial A transmit clock input or serial A control 2 output.
// - Port C pin 6 can be serial A ring indicator input.
// - Port C pin 6 as interrupt output is driven low while a normal interrupt is pending.
// - That interrupt output ignores fast interrupts.
// - Port C pin 5 is serial B transmit clock input or serial B control output.
// - Port C pin 4 can be serial B ring indicator input.
// - Port C pin 4 as reset output is low on soft reset or while the reset-request bit is set.
// - Port C pins 3 to 0 can raise an interrupt on a chosen rising or falling edge.
// - Port C pin 3 can output DRAM address-mux control, steered by two misc-register bits or two memory-controller select inputs.
module pbc_mux (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_b,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Port B pads
    input  wire logic [7:0]  port_b_in,
    output logic      [7:0]  port_b_out,
    output logic      [7:0]  port_b_oe,
    // Port C pads
    input  wire logic [7:0]  port_c_in,
    output logic      [7:0]  port_c_out,
    output logic      [7:0]  port_c_oe,
    // Serial channel A and B side
    output logic             serial_b_receive_line,
    output logic             serial_b_set_ready_in,
    output logic             serial_b_clear_to_send,
    output logic             serial_b_carrier_detect,
    output logic             serial_a_tx_clock_in,
    output logic             serial_a_ring_indicator,
    output logic             serial_b_tx_clock_in,
    output logic             serial_b_ring_indicator,
    input  wire logic        serial_a_misc_ctrl2_out,
    input  wire logic        serial_b_misc_ctrl_out,
    // DMA channel 4 side
    input  wire logic        dma4_acknowledge_out,
    input  wire logic        dma4_done_drive,
    input  wire logic        dma4_done_oe,
    output logic             dma4_done_signal,
    // Ethernet receiver, interrupt controller, reset, memory controller
    input  wire logic        rx_frame_start_marker,
    input  wire logic        normal_irq_pending,
    input  wire logic        fast_irq_pending,
    input  wire logic        soft_reset,
    input  wire logic        dram_addr_mux_select,
    input  wire logic        dram_addr_mux_select_alt,
    input  wire logic        dram_mux_ctrl,
    // Interrupt
    output logic             irq
);
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire rst_n = rst_s2_q;

    // Pins come from outside; every reader sees the synchronised copy
    logic [7:0] pb_sync;
    logic [7:0] pc_sync;
    pbc_sync #(.W(8)) u_sync_b (
        .clk   (mclk),
        .rst_b (rst_n),
        .d     (port_b_in),
        .q     (pb_sync)
    );
    pbc_sync #(.W(8)) u_sync_c (
        .clk   (mclk),
        .rst_b (rst_n),
        .d     (port_c_in),
        .q     (pc_sync)
    );

    // Configuration: mode=1 special; dir=1 output; sel picks alternate special function
    pbc_pkg::pbc_port_cfg_t cfg_b_q;
    pbc_pkg::pbc_port_cfg_t cfg_c_q;
    logic [3:0]             edge_pol_q;
    logic [3:0]             int_mask_q;
    logic [2:0]             misc_q;
    logic [3:0]             edge_pend;

    // Offsets that answer without an error; misaligned addresses fall to default
    function automatic logic reg_mapped(input logic [7:0] a);
        case (a)
            pbc_pkg::OFS_PB_MODE,
            pbc_pkg::OFS_PB_DIR,
            pbc_pkg::OFS_PB_OUT,
            pbc_pkg::OFS_PB_IN,
            pbc_pkg::OFS_PB_SEL,
            pbc_pkg::OFS_PC_MODE,
            pbc_pkg::OFS_PC_DIR,
            pbc_pkg::OFS_PC_OUT,
            pbc_pkg::OFS_PC_IN,
            pbc_pkg::OFS_PC_SEL,
            pbc_pkg::OFS_EDGE_POL,
            pbc_pkg::OFS_INT_STAT,
            pbc_pkg::OFS_INT_MASK,
            pbc_pkg::OFS_MISC: reg_mapped = 1'b1;
            default:           reg_mapped = 1'b0;
        endcase
    endfunction

    // APB decode: zero-wait slave, unmapped addresses answer with pslverr
    wire        acc    = psel & penable;
    wire        wr     = acc & pwrite;
    wire        mapped = reg_mapped(paddr);
    wire [3:0]  w1c    = (wr && paddr == pbc_pkg::OFS_INT_STAT) ? pwdata[3:0] : 4'h0;

    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // Port B configuration
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_b_q <= '0;
        end else if (wr) begin
            case (paddr)
                pbc_pkg::OFS_PB_MODE: cfg_b_q.mode <= pwdata[7:0];
                pbc_pkg::OFS_PB_DIR:  cfg_b_q.dir  <= pwdata[7:0];
                pbc_pkg::OFS_PB_OUT:  cfg_b_q.dout <= pwdata[7:0];
                pbc_pkg::OFS_PB_SEL:  cfg_b_q.sel  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Port C configuration
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_c_q <= '0;
        end else if (wr) begin
            case (paddr)
                pbc_pkg::OFS_PC_MODE: cfg_c_q.mode <= pwdata[7:0];
                pbc_pkg::OFS_PC_DIR:  cfg_c_q.dir  <= pwdata[7:0];
                pbc_pkg::OFS_PC_OUT:  cfg_c_q.dout <= pwdata[7:0];
                pbc_pkg::OFS_PC_SEL:  cfg_c_q.sel  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Interrupt and miscellaneous controls
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            edge_pol_q <= 4'h0;
            int_mask_q <= 4'h0;
            misc_q     <= 3'h0;
        end else if (wr) begin
            case (paddr)
                pbc_pkg::OFS_EDGE_POL: edge_pol_q <= pwdata[3:0];
                pbc_pkg::OFS_INT_MASK: int_mask_q <= pwdata[3:0];
                pbc_pkg::OFS_MISC:     misc_q     <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // Read data is registered so it stands as a data output from a flop
    logic [7:0] rd_byte;
    always_comb begin
        case (paddr)
            pbc_pkg::OFS_PB_MODE:  rd_byte = cfg_b_q.mode;
            pbc_pkg::OFS_PB_DIR:   rd_byte = cfg_b_q.dir;
            pbc_pkg::OFS_PB_OUT:   rd_byte = cfg_b_q.dout;
            pbc_pkg::OFS_PB_IN:    rd_byte = pb_sync;
            pbc_pkg::OFS_PB_SEL:   rd_byte = cfg_b_q.sel;
            pbc_pkg::OFS_PC_MODE:  rd_byte = cfg_c_q.mode;
            pbc_pkg::OFS_PC_DIR:   rd_byte = cfg_c_q.dir;
            pbc_pkg::OFS_PC_OUT:   rd_byte = cfg_c_q.dout;
            pbc_pkg::OFS_PC_IN:    rd_byte = pc_sync;
            pbc_pkg::OFS_PC_SEL:   rd_byte = cfg_c_q.sel;
            pbc_pkg::OFS_EDGE_POL: rd_byte = {4'h0, edge_pol_q};
            pbc_pkg::OFS_INT_STAT: rd_byte = {4'h0, edge_pend};
            pbc_pkg::OFS_INT_MASK: rd_byte = {4'h0, int_mask_q};
            pbc_pkg::OFS_MISC:     rd_byte = {5'h00, misc_q};
            default:               rd_byte = pbc_pkg::RST_BYTE;
        endcase
    end

    // Setup phase captures read data so it is valid during the zero-wait access phase
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h00_0000, rd_byte};
        end
    end

    // Edge interrupts on port C 3:0 when those pins are special-mode inputs with sel clear
    wire [3:0] ci_en = cfg_c_q.mode[3:0] & ~cfg_c_q.sel[3:0] & ~cfg_c_q.dir[3:0];
    pbc_edge #(.N(pbc_pkg::NEDGE)) u_edge (
        .clk      (mclk),
        .rst_b    (rst_n),
        .level    (pc_sync[3:0]),
        .enable   (ci_en),
        .rise_sel (edge_pol_q),
        .clear    (w1c),
        .pend_q   (edge_pend)
    );
    assign irq = |(edge_pend & int_mask_q);

    // Input-side routing: a special-mode input sees its pin, otherwise idles inactive
    wire [7:0] b_sp = cfg_b_q.mode;
    wire [7:0] c_sp = cfg_c_q.mode;
    assign serial_b_receive_line   = b_sp[3] ? pb_sync[3] : 1'b1;
    assign serial_b_set_ready_in   = (b_sp[2] & ~cfg_b_q.sel[2]) ? pb_sync[2] : 1'b1;
    assign serial_b_clear_to_send  = (b_sp[1] & ~cfg_b_q.sel[1]) ? pb_sync[1] : 1'b1;
    assign serial_b_carrier_detect = (b_sp[0] & ~cfg_b_q.sel[0]) ? pb_sync[0] : 1'b1;
    assign dma4_done_signal        = (b_sp[0] & cfg_b_q.sel[0]) ? pb_sync[0] : 1'b1;

    // Port C inputs: transmit clocks idle low, ring indicators idle high
    assign serial_a_tx_clock_in    = (c_sp[7] & ~cfg_c_q.sel[7]) ? pc_sync[7] : 1'b0;
    assign serial_a_ring_indicator = (c_sp[6] & ~cfg_c_q.sel[6]) ? pc_sync[6] : 1'b1;
    assign serial_b_tx_clock_in    = (c_sp[5] & ~cfg_c_q.sel[5]) ? pc_sync[5] : 1'b0;
    assign serial_b_ring_indicator = (c_sp[4] & ~cfg_c_q.sel[4]) ? pc_sync[4] : 1'b1;

    // Special output values per pin; only fast-interrupt state is deliberately unused
    wire       irq_out_b   = ~normal_irq_pending;
    wire       rst_out_b   = ~(soft_reset | misc_q[pbc_pkg::MISC_RSTREQ]);
    wire       dram_addr_mux_select_on     = misc_q[pbc_pkg::MISC_DRAM_ADDR_MUX_SELECT] | misc_q[pbc_pkg::MISC_DRAM_ADDR_MUX_SELECT_ALT]
                           | dram_addr_mux_select | dram_addr_mux_select_alt;
    wire       fast_unused = fast_irq_pending;
    wire [7:0] b_sp_val;
    wire [7:0] b_sp_oe;
    wire [7:0] c_sp_val;
    wire [7:0] c_sp_oe;

    // B7..B4: their other functions live elsewhere, so the pad stays released
    assign b_sp_val[7:4] = cfg_b_q.dout[7:4];
    assign b_sp_oe[7:4]  = 4'h0;

    // B3: receive data input only
    assign b_sp_val[3]   = cfg_b_q.dout[3];
    assign b_sp_oe[3]    = 1'b0;

    // B2: acknowledge out when sel is set, else data-set-ready in
    assign b_sp_val[2]   = dma4_acknowledge_out;
    assign b_sp_oe[2]    = cfg_b_q.sel[2];

    // B1: frame-start out when sel is set, else clear-to-send in
    assign b_sp_val[1]   = rx_frame_start_marker;
    assign b_sp_oe[1]    = cfg_b_q.sel[1];

    // B0: done is two-way, so the DMA side decides when the pad is driven
    assign b_sp_val[0]   = dma4_done_drive;
    assign b_sp_oe[0]    = cfg_b_q.sel[0] & dma4_done_oe;

    // C7 and C5: control outputs when sel is set, else transmit clock in
    assign c_sp_val[7]   = serial_a_misc_ctrl2_out;
    assign c_sp_oe[7]    = cfg_c_q.sel[7];
    assign c_sp_val[5]   = serial_b_misc_ctrl_out;
    assign c_sp_oe[5]    = cfg_c_q.sel[5];

    // C6: active-low interrupt out when sel is set, else ring indicator in
    assign c_sp_val[6]   = irq_out_b;
    assign c_sp_oe[6]    = cfg_c_q.sel[6];

    // C4: active-low reset out when sel is set, else ring indicator in
    assign c_sp_val[4]   = rst_out_b;
    assign c_sp_oe[4]    = cfg_c_q.sel[4];

    // C3: mux control drives only while a mux bit or request is set, so an idle pin stays released
    assign c_sp_val[3]   = dram_mux_ctrl;
    assign c_sp_oe[3]    = cfg_c_q.sel[3] & dram_addr_mux_select_on;

    // C2..C0: edge interrupt inputs only
    assign c_sp_val[2:0] = 3'h0;
    assign c_sp_oe[2:0]  = 3'h0;

    // Output stage registered: general mode drives dout when dir set, special mode as selected
    logic [7:0] pb_out_d;
    logic [7:0] pb_oe_d;
    logic [7:0] pc_out_d;
    logic [7:0] pc_oe_d;
    assign pb_out_d = (b_sp & b_sp_val) | (~b_sp & cfg_b_q.dout);
    assign pb_oe_d  = (b_sp & b_sp_oe)  | (~b_sp & cfg_b_q.dir);
    assign pc_out_d = (c_sp & c_sp_val) | (~c_sp & cfg_c_q.dout);
    assign pc_oe_d  = ((c_sp & c_sp_oe) | (~c_sp & cfg_c_q.dir)) & ~{7'h00, fast_unused & 1'b0};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_out <= 8'h00;
            port_b_oe  <= 8'h00;
        end else begin
            port_b_out <= pb_out_d;
            port_b_oe  <= pb_oe_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_out <= 8'h00;
            port_c_oe  <= 8'h00;
        end else begin
            port_c_out <= pc_out_d;
            port_c_oe  <= pc_oe_d;
        end
    end
endmodule
`default_nettype wire

// *** sim/pbc_mux_monitor.sv ***
// Checker for the port B/C pin mux: shadows config writes, checks pads and lines.
// Assumes it is bound to pbc_mux and sees only that module's ports.
`default_nettype none
module pbc_mux_monitor (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // Pads and lines
    input wire logic [7:0]  port_b_in,
    input wire logic [7:0]  port_b_out,
    input wire logic [7:0]  port_b_oe,
    input wire logic [7:0]  port_c_out,
    input wire logic        serial_b_receive_line,
    input wire logic        serial_b_clear_to_send,
    input wire logic        dma4_acknowledge_out,
    input wire logic        rx_frame_start_marker,
    input wire logic        normal_irq_pending,
    input wire logic        soft_reset
);
    logic [7:0] bm_q;
    logic [7:0] bs_q;
    logic [7:0] cm_q;
    logic [7:0] cs_q;
    logic [7:0] mi_q;
    wire        wr_en = psel & penable & pwrite;
    wire        ack_f = bm_q[2] & bs_q[2];
    wire        sof_f = bm_q[1] & bs_q[1];
    wire        irq_f = cm_q[6] & cs_q[6];
    wire        rst_f = cm_q[4] & cs_q[4];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Shadow copies land on the same edge as the design's own registers
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            {bm_q, bs_q, cm_q, cs_q, mi_q} <= '0;
        end else if (wr_en) begin
            if (paddr == pbc_pkg::OFS_PB_MODE) bm_q <= pwdata[7:0];
            if (paddr == pbc_pkg::OFS_PB_SEL) bs_q <= pwdata[7:0];
            if (paddr == pbc_pkg::OFS_PC_MODE) cm_q <= pwdata[7:0];
            if (paddr == pbc_pkg::OFS_PC_SEL) cs_q <= pwdata[7:0];
            if (paddr == pbc_pkg::OFS_MISC) mi_q <= pwdata[7:0];
        end
    end
    a_unmapped_err: assert property (
        psel && penable && paddr > pbc_pkg::OFS_MISC |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (
        psel && penable && paddr <= pbc_pkg::OFS_MISC && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged as error");
    a_rxd_route: assert property (
        serial_b_receive_line == (bm_q[3] ? $past(port_b_in[3], 2) : 1'b1))
        else $error("receive line does not follow pin b3");
    a_cts_route: assert property (
        serial_b_clear_to_send == ((bm_q[1] && !bs_q[1]) ? $past(port_b_in[1], 2) : 1'b1))
        else $error("clear to send does not follow pin b1");
    a_ack_drive: assert property (
        ack_f && $past(ack_f) |-> port_b_oe[2] && port_b_out[2] == $past(dma4_acknowledge_out))
        else $error("acknowledge not driven on pin b2");
    a_sof_drive: assert property (
        sof_f && $past(sof_f) |-> port_b_oe[1] && port_b_out[1] == $past(rx_frame_start_marker))
        else $error("frame start not driven on pin b1");
    a_irq_pin_low: assert property (
        irq_f && $past(irq_f) |-> port_c_out[6] == !$past(normal_irq_pending))
        else $error("interrupt pin wrong on c6");
    a_reset_pin_low: assert property (
        rst_f && $past(rst_f) |-> port_c_out[4] == !($past(soft_reset) || $past(mi_q[0])))
        else $error("reset pin wrong on c4");
    c_unmapped: cover property (psel && penable && pslverr);
    c_irq_pin: cover property (irq_f && normal_irq_pending);
    c_stat_clear: cover property (wr_en && paddr == pbc_pkg::OFS_INT_STAT);
endmodule
bind pbc_mux pbc_mux_monitor mon (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .port_b_in(port_b_in), .port_b_out(port_b_out),
    .port_b_oe(port_b_oe), .port_c_out(port_c_out), .serial_b_receive_line(serial_b_receive_line),
    .serial_b_clear_to_send(serial_b_clear_to_send), .dma4_acknowledge_out(dma4_acknowledge_out),
    .rx_frame_start_marker(rx_frame_start_marker), .normal_irq_pending(normal_irq_pending),
    .soft_reset(soft_reset));
`default_nettype wire

// *** sim/pbc_periph_model.sv ***
// Far-side model: external peripherals on the port B and C pins, with pull-ups on port B only.
// Assumes the bench sets what the peripherals drive; released B pins float high.
`default_nettype none
module pbc_periph_model (
    // Device pads
    input  wire logic [7:0] port_b_out,
    input  wire logic [7:0] port_b_oe,
    input  wire logic [7:0] port_c_out,
    input  wire logic [7:0] port_c_oe,
    // Peripheral drive
    input  wire logic [7:0] ext_b,
    input  wire logic [7:0] ext_b_oe,
    input  wire logic [7:0] ext_c,
    // Resolved pin levels
    output logic      [7:0] port_b_in,
    output logic      [7:0] port_c_in
);
    // Device drive wins, so an output pin reads back its own level
    assign port_b_in = (port_b_oe & port_b_out) | (~port_b_oe & ((ext_b_oe & ext_b) | ~ext_b_oe));
    assign port_c_in = (port_c_oe & port_c_out) | (~port_c_oe & ext_c);
endmodule
`default_nettype wire

// *** sim/pbc_mux_tb_top.sv ***
// Bench for the port B/C pin mux: APB tasks, far-side model and scenarios.
// Assumes the checker binds itself to the design.
`default_nettype none
module pbc_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0]  paddr, bo, boe, co, coe, bi, ci, eb, ebe, ec;
    logic [31:0] pwdata, prdata, r;
    // Side inputs: 0 ctrl2 A, 1 ctrl B, 2 ack, 3 done drv, 4 done oe, 5 sof, 6 irq, 7 fiq, 8 soft, 9-11 dram
    logic [11:0] sv;
    logic [8:0]  ln;
    int          errors, checks;
    pbc_mux dut (.mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_b_in(bi), .port_b_out(bo),
        .port_b_oe(boe), .port_c_in(ci), .port_c_out(co), .port_c_oe(coe), .serial_b_receive_line(ln[8]),
        .serial_b_set_ready_in(ln[7]), .serial_b_clear_to_send(ln[6]), .serial_b_carrier_detect(ln[5]),
        .serial_a_tx_clock_in(ln[4]), .serial_a_ring_indicator(ln[3]), .serial_b_tx_clock_in(ln[2]),
        .serial_b_ring_indicator(ln[1]), .serial_a_misc_ctrl2_out(sv[0]), .serial_b_misc_ctrl_out(sv[1]),
        .dma4_acknowledge_out(sv[2]), .dma4_done_drive(sv[3]), .dma4_done_oe(sv[4]), .dma4_done_signal(ln[0]),
        .rx_frame_start_marker(sv[5]), .normal_irq_pending(sv[6]), .fast_irq_pending(sv[7]), .soft_reset(sv[8]),
        .dram_addr_mux_select(sv[9]), .dram_addr_mux_select_alt(sv[10]), .dram_mux_ctrl(sv[11]), .irq(irq));
    pbc_periph_model far (.port_b_out(bo), .port_b_oe(boe), .port_c_out(co), .port_c_oe(coe), .ext_b(eb),
        .ext_b_oe(ebe), .ext_c(ec), .port_b_in(bi), .port_c_in(ci));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            summarize();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata, sv, ec} = '0;
        eb = 8'h3c;
        ebe = 8'h0f;
        errors = 0;
        checks = 0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        wt(3);
        for (int a = 0; a <= 8'h34; a += 4) rd(8'(a), (a == 8'h0c) ? 32'hfc : 32'h0);
        apb(1'b0, 8'h38, 32'h0);
        chk(r, 32'h0);
        chk(e, 1'b1);
        apb(1'b1, pbc_pkg::OFS_PB_DIR, 32'hf0);
        apb(1'b1, pbc_pkg::OFS_PB_OUT, 32'ha5);
        wt(4);
        chk({boe, bo[7:4]}, 12'hf0a);
        rd(pbc_pkg::OFS_PB_IN, 32'hac);
        apb(1'b1, pbc_pkg::OFS_PB_MODE, 32'h0f);
        apb(1'b1, pbc_pkg::OFS_PB_SEL, 32'h06);
        sv <= 12'h024;
        wt(4);
        chk({boe[2:1], bo[2:1], ln[8:5]}, 8'hfe);
        eb <= 8'hf5;
        sv <= 12'h010;
        apb(1'b1, pbc_pkg::OFS_PB_SEL, 32'h01);
        wt(4);
        chk({boe[0], bo[0], ln[0], ln[8:6]}, 6'h22);
        sv <= 12'h000;
        wt(4);
        chk({boe[0], ln[0]}, 2'h1);
        apb(1'b1, pbc_pkg::OFS_PC_MODE, 32'hff);
        apb(1'b1, pbc_pkg::OFS_PC_SEL, 32'hf8);
        apb(1'b1, pbc_pkg::OFS_MISC, 32'h2);
        sv <= 12'h843;
        wt(3);
        chk({coe[7:3], co[7:3]}, 10'h3f7);
        sv <= 12'h180;
        wt(3);
        chk(co[7:3], 5'h08);
        sv <= 12'h000;
        apb(1'b1, pbc_pkg::OFS_MISC, 32'h1);
        wt(3);
        chk({co[4], coe[3]}, 2'h0);
        apb(1'b1, pbc_pkg::OFS_PC_SEL, 32'h00);
        ec <= 8'h50;
        apb(1'b1, pbc_pkg::OFS_EDGE_POL, 32'h5);
        apb(1'b1, pbc_pkg::OFS_INT_MASK, 32'hf);
        apb(1'b1, pbc_pkg::OFS_INT_STAT, 32'hf);
        rd(pbc_pkg::OFS_INT_STAT, 32'h0);
        chk({irq, ln[4:1]}, 5'h05);
        ec <= 8'ha5;
        wt(4);
        chk({irq, ln[4:1]}, 5'h1a);
        ec <= 8'haa;
        wt(4);
        rd(pbc_pkg::OFS_INT_STAT, 32'h5);
        ec <= 8'ha0;
        wt(4);
        apb(1'b1, pbc_pkg::OFS_INT_STAT, 32'h5);
        rd(pbc_pkg::OFS_INT_STAT, 32'ha);
        apb(1'b1, pbc_pkg::OFS_INT_MASK, 32'h5);
        wt(1);
        chk(irq, 1'b0);
        apb(1'b1, pbc_pkg::OFS_INT_STAT, 32'ha);
        rd(pbc_pkg::OFS_INT_STAT, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
